// ===== rqd_params.svh
// Register offsets, reset values and timing constants of the qualify block
`ifndef RQD_PARAMS_SVH
`define RQD_PARAMS_SVH

`define RQD_ADDR_MASK_LO 7'h1A
`define RQD_ADDR_MASK_HI 7'h1B
`define RQD_ADDR_QUAL_TIME 7'h1C
`define RQD_ADDR_CTRL_A 7'h1D
`define RQD_ADDR_CTRL_B 7'h1E
`define RQD_ADDR_MODE_SEL 7'h1F
`define RQD_ADDR_QUAL_STATUS 7'h19

`define RQD_RST_MASK_LO 8'hFF
`define RQD_RST_MASK_HI 8'hFF
`define RQD_RST_QUAL_TIME 8'h1A
`define RQD_RST_CTRL_A 8'h3A
`define RQD_RST_CTRL_B 8'h04
`define RQD_RST_MODE_SEL 8'h03

`define RQD_POS_DISQ 0
`define RQD_POS_REQ_MULT 4
`define RQD_POS_BUILDOUT 0
`define RQD_POS_BW 1
`define RQD_POS_SLOPE 4
`define RQD_POS_REVERT 0
`define RQD_POS_OFFS_EN 1

`define RQD_CLK_PERIOD_NS 8
`define RQD_TICK_TIME_NS 500000

`endif

// ===== rqd_pkg.sv
// Types shared by the reference qualify and loop control block
package rqd_pkg;
    localparam int NUM_REF = 5;
    localparam int DTICK_W = 17;
    localparam int QCNT_W = 22;

    typedef logic [QCNT_W-1:0] rqd_cnt_t;

    typedef enum logic [2:0] {
        BW_0P1HZ,
        BW_1P7HZ,
        BW_3P5HZ,
        BW_14HZ,
        BW_28HZ,
        BW_890HZ,
        BW_FAST_7HZ,
        BW_RESERVED
    } rqd_bw_e;

    typedef enum logic [1:0] {
        SLOPE_885NS,
        SLOPE_7P5US,
        SLOPE_61US,
        SLOPE_UNLIMITED
    } rqd_slope_e;
endpackage

// ===== rqd_ctrl.sv
// Reference guard soak qualification and transmit loop control registers
// Operation
// - Each reference has two inhibit bits, low for single-cycle and high for coarse-frequency failure, a set bit blocking that input to the soak timer.
// - A four-bit code picks the disqualify delay, 0000 being the shortest and the others stepping from 0.5 ms to 64 s.
// - The requalify delay is the disqualify delay times 2, 4, 16 or 32 by a two-bit code.
// - With the hitless control at 0 the loop builds out the phase step of a reference change, at 1 it realigns to the new phase.
// - A three-bit code selects loop bandwidth 0.1, 1.7, 3.5, 14, 28, 890 Hz, fast lock 7 Hz, or reserved, with 890 Hz at reset.
// - The bandwidth is capped at 14 Hz for 2 kHz references on the 28 and 890 Hz settings and at 56 Hz for 890 Hz with 8 kHz references.
// - A two-bit code limits the output phase slope to 885 ns/s, 7.5 us/s, 61 us/s or unlimited, the last at reset.
// - The revertive control at 1 lets automatic switching return to a requalified higher-priority reference, at 0 it does not.
// - The offset enable at 1 applies the free-run frequency offset, off at reset, and software sets it only in free-run mode.
// - Hitless switching with phase build-out is in effect straight after reset.
`timescale 1ns/10ps
`include "rqd_params.svh"

module rqd_ctrl
    import rqd_pkg::*;
#(
    parameter int TICK_CYCLES = `RQD_TICK_TIME_NS / `RQD_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // Register port behind the serial interface
    input wire logic [6:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Monitor failures, one bit per reference
    input wire logic [NUM_REF-1:0] SINGLE_CYCLE_MONITOR_FAIL,
    input wire logic [NUM_REF-1:0] COARSE_FREQUENCY_MONITOR_FAIL,
    // Rate of the reference currently locked to
    input wire logic LOCKED_REF_2KHZ,
    input wire logic LOCKED_REF_8KHZ,
    // Qualification results
    output logic [NUM_REF-1:0] REF_QUALIFIED,
    // Loop controls
    output logic PHASE_BUILDOUT_EN,
    output logic [2:0] EFF_BANDWIDTH,
    output logic BW_CAP_56HZ,
    output logic [1:0] PHASE_SLOPE_LIMIT,
    output logic REVERTIVE_EN,
    output logic FREQ_OFFSET_APPLY,
    output logic [2:0] LOOP_MODE
);

    // The time base prescaler is 16 bits wide
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    typedef struct packed {
        logic [7:0] mask_lo;
        logic [7:0] mask_hi;
        logic [7:0] qual_time;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] mode_sel;
        logic [7:0] rdata;
        logic [15:0] presc;
        logic tick;
        logic [NUM_REF-1:0] qualified;
        logic [NUM_REF-1:0][QCNT_W-1:0] fail_acc;
        logic [NUM_REF-1:0][QCNT_W-1:0] good_cnt;
        logic buildout;
        logic [2:0] eff_bw;
        logic cap56;
        logic [1:0] slope;
        logic revert;
        logic offs;
        logic [2:0] mode;
    } rqd_state_s;

    rqd_state_s st_ff;
    rqd_state_s nxt_st;

    // Disqualify delay in 0.5 ms ticks
    function automatic rqd_cnt_t disq_ticks(input logic [3:0] code);
        logic [DTICK_W-1:0] t;
        t = '0;
        case (code)
            4'h0: t = 17'h00000;
            4'h1: t = 17'd1;
            4'h2: t = 17'd2;
            4'h3: t = 17'd10;
            4'h4: t = 17'd20;
            4'h5: t = 17'd100;
            4'h6: t = 17'd200;
            4'h7: t = 17'd1000;
            4'h8: t = 17'd2000;
            4'h9: t = 17'd4000;
            4'hA: t = 17'd5000;
            4'hB: t = 17'd8000;
            4'hC: t = 17'd16000;
            4'hD: t = 17'd32000;
            4'hE: t = 17'd64000;
            default: t = 17'd128000;
        endcase
        return QCNT_W'(t);
    endfunction

    function automatic rqd_cnt_t qual_ticks(input rqd_cnt_t d,
                                            input logic [1:0] m);
        rqd_cnt_t q;
        q = '0;
        case (m)
            2'h0: q = QCNT_W'(d << 1);
            2'h1: q = QCNT_W'(d << 2);
            2'h2: q = QCNT_W'(d << 4);
            default: q = QCNT_W'(d << 5);
        endcase
        return q;
    endfunction

    logic [2*NUM_REF-1:0] all_mask;
    rqd_cnt_t disq_lim;
    rqd_cnt_t qual_lim;
    assign all_mask = {st_ff.mask_hi[1:0], st_ff.mask_lo};
    assign disq_lim = disq_ticks(st_ff.qual_time[`RQD_POS_DISQ +: 4]);
    assign qual_lim = qual_ticks(disq_lim,
                      st_ff.qual_time[`RQD_POS_REQ_MULT +: 2]);

    always_comb begin
        logic fail;
        logic [2:0] bw;
        nxt_st = st_ff;
        fail = 1'b0;
        bw = 3'h0;

        // Register writes
        if (REG_WR) begin
            if (REG_ADDR == `RQD_ADDR_MASK_LO) begin
                nxt_st.mask_lo = REG_WDATA;
            end else if (REG_ADDR == `RQD_ADDR_MASK_HI) begin
                nxt_st.mask_hi = REG_WDATA;
            end else if (REG_ADDR == `RQD_ADDR_QUAL_TIME) begin
                nxt_st.qual_time = REG_WDATA;
            end else if (REG_ADDR == `RQD_ADDR_CTRL_A) begin
                nxt_st.ctrl_a = REG_WDATA;
            end else if (REG_ADDR == `RQD_ADDR_CTRL_B) begin
                nxt_st.ctrl_b = REG_WDATA;
            end else if (REG_ADDR == `RQD_ADDR_MODE_SEL) begin
                nxt_st.mode_sel = REG_WDATA;
            end
        end

        // Register reads, captured for the serial side
        if (REG_RD) begin
            if (REG_ADDR == `RQD_ADDR_MASK_LO) begin
                nxt_st.rdata = st_ff.mask_lo;
            end else if (REG_ADDR == `RQD_ADDR_MASK_HI) begin
                nxt_st.rdata = st_ff.mask_hi;
            end else if (REG_ADDR == `RQD_ADDR_QUAL_TIME) begin
                nxt_st.rdata = st_ff.qual_time;
            end else if (REG_ADDR == `RQD_ADDR_CTRL_A) begin
                nxt_st.rdata = st_ff.ctrl_a;
            end else if (REG_ADDR == `RQD_ADDR_CTRL_B) begin
                nxt_st.rdata = st_ff.ctrl_b;
            end else if (REG_ADDR == `RQD_ADDR_MODE_SEL) begin
                nxt_st.rdata = st_ff.mode_sel;
            end else if (REG_ADDR == `RQD_ADDR_QUAL_STATUS) begin
                nxt_st.rdata = {3'h0, st_ff.qualified};
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end

        // 0.5 ms time base
        if (st_ff.presc >= 16'(TICK_CYCLES - 1)) begin
            nxt_st.presc = 16'h0000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.presc = st_ff.presc + 16'h0001;
            nxt_st.tick = 1'b0;
        end

        // Guard soak timers
        for (int i = 0; i < NUM_REF; i++) begin
            fail = (SINGLE_CYCLE_MONITOR_FAIL[i] & ~all_mask[2*i]) |
                   (COARSE_FREQUENCY_MONITOR_FAIL[i] &
                    ~all_mask[2*i+1]);
            if (st_ff.qualified[i]) begin
                nxt_st.good_cnt[i] = '0;
                if (fail && st_ff.fail_acc[i] >= disq_lim) begin
                    nxt_st.qualified[i] = 1'b0;
                    nxt_st.fail_acc[i] = '0;
                end else if (st_ff.tick && fail) begin
                    nxt_st.fail_acc[i] = st_ff.fail_acc[i] + 1'b1;
                end else if (st_ff.tick && st_ff.fail_acc[i] != '0) begin
                    nxt_st.fail_acc[i] = st_ff.fail_acc[i] - 1'b1;
                end
            end else begin
                nxt_st.fail_acc[i] = '0;
                if (fail) begin
                    nxt_st.good_cnt[i] = '0;
                end else if (st_ff.good_cnt[i] >= qual_lim) begin
                    nxt_st.qualified[i] = 1'b1;
                    nxt_st.good_cnt[i] = '0;
                end else if (st_ff.tick) begin
                    nxt_st.good_cnt[i] = st_ff.good_cnt[i] + 1'b1;
                end
            end
        end

        // Loop control outputs
        nxt_st.buildout = ~st_ff.ctrl_a[`RQD_POS_BUILDOUT];
        bw = st_ff.ctrl_a[`RQD_POS_BW +: 3];
        nxt_st.cap56 = 1'b0;
        if (LOCKED_REF_2KHZ && (bw == BW_28HZ || bw == BW_890HZ)) begin
            nxt_st.eff_bw = BW_14HZ;
        end else if (LOCKED_REF_8KHZ && bw == BW_890HZ) begin
            nxt_st.eff_bw = bw;
            nxt_st.cap56 = 1'b1;
        end else begin
            nxt_st.eff_bw = bw;
        end
        nxt_st.slope = st_ff.ctrl_a[`RQD_POS_SLOPE +: 2];
        nxt_st.revert = st_ff.ctrl_b[`RQD_POS_REVERT];
        nxt_st.offs = st_ff.ctrl_b[`RQD_POS_OFFS_EN];
        nxt_st.mode = st_ff.mode_sel[2:0];
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            st_ff <= '0;
            st_ff.mask_lo <= `RQD_RST_MASK_LO;
            st_ff.mask_hi <= `RQD_RST_MASK_HI;
            st_ff.qual_time <= `RQD_RST_QUAL_TIME;
            st_ff.ctrl_a <= `RQD_RST_CTRL_A;
            st_ff.ctrl_b <= `RQD_RST_CTRL_B;
            st_ff.mode_sel <= `RQD_RST_MODE_SEL;
            st_ff.buildout <= 1'b1;
            st_ff.eff_bw <= BW_890HZ;
            st_ff.slope <= SLOPE_UNLIMITED;
            st_ff.mode <= 3'h3;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA = st_ff.rdata;
    assign REF_QUALIFIED = st_ff.qualified;
    assign PHASE_BUILDOUT_EN = st_ff.buildout;
    assign EFF_BANDWIDTH = st_ff.eff_bw;
    assign BW_CAP_56HZ = st_ff.cap56;
    assign PHASE_SLOPE_LIMIT = st_ff.slope;
    assign REVERTIVE_EN = st_ff.revert;
    assign FREQ_OFFSET_APPLY = st_ff.offs;
    assign LOOP_MODE = st_ff.mode;

endmodule

// ===== rqd_ctrl_properties.sv
// Concurrent checks on the register port and loop control outputs
`timescale 1ns/10ps
module rqd_ctrl_properties (
    // Clock, reset and register port
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [6:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Reference rate and loop controls
    input wire logic LOCKED_REF_2KHZ,
    input wire logic LOCKED_REF_8KHZ,
    input wire logic PHASE_BUILDOUT_EN,
    input wire logic [2:0] EFF_BANDWIDTH,
    input wire logic BW_CAP_56HZ,
    input wire logic [1:0] PHASE_SLOPE_LIMIT,
    input wire logic REVERTIVE_EN,
    input wire logic FREQ_OFFSET_APPLY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    property p_buildout;
        REG_WR && REG_ADDR == 7'h1D |-> ##2
            PHASE_BUILDOUT_EN == !$past(REG_WDATA[0], 2);
    endproperty
    a_buildout: assert property (p_buildout) else $error("buildout");
    property p_slope;
        REG_WR && REG_ADDR == 7'h1D |-> ##2
            PHASE_SLOPE_LIMIT == $past(REG_WDATA[5:4], 2);
    endproperty
    a_slope: assert property (p_slope) else $error("slope limit");
    property p_revert;
        REG_WR && REG_ADDR == 7'h1E |-> ##2
            REVERTIVE_EN == $past(REG_WDATA[0], 2);
    endproperty
    a_revert: assert property (p_revert) else $error("revertive");
    property p_offs;
        REG_WR && REG_ADDR == 7'h1E |-> ##2
            FREQ_OFFSET_APPLY == $past(REG_WDATA[1], 2);
    endproperty
    a_offs: assert property (p_offs) else $error("offset enable");
    property p_bw;
        (REG_WR && REG_ADDR == 7'h1D && !LOCKED_REF_2KHZ) ##1 !LOCKED_REF_2KHZ
            |=> EFF_BANDWIDTH == $past(REG_WDATA[3:1], 2);
    endproperty
    a_bw: assert property (p_bw) else $error("bandwidth code");
    property p_cap2k;
        $past(RST_B) && $past(LOCKED_REF_2KHZ) |->
            !(EFF_BANDWIDTH inside {3'h4, 3'h5});
    endproperty
    a_cap2k: assert property (p_cap2k) else $error("2k cap");
    property p_cap56;
        $past(RST_B) |-> BW_CAP_56HZ == (EFF_BANDWIDTH == 3'h5
            && $past(LOCKED_REF_8KHZ) && !$past(LOCKED_REF_2KHZ));
    endproperty
    a_cap56: assert property (p_cap56) else $error("56 Hz cap");
    property p_readback;
        REG_WR && REG_ADDR inside {7'h1A, 7'h1B, 7'h1C} ##1 !REG_WR ##1 REG_RD
            && REG_ADDR == $past(REG_ADDR, 2) |=> REG_RDATA == $past(REG_WDATA, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("readback");
endmodule
bind rqd_ctrl rqd_ctrl_properties u_props (.CLK_SYS, .RST_B, .REG_ADDR, .REG_WR,
    .REG_WDATA, .REG_RD, .REG_RDATA, .LOCKED_REF_2KHZ, .LOCKED_REF_8KHZ,
    .PHASE_BUILDOUT_EN, .EFF_BANDWIDTH, .BW_CAP_56HZ, .PHASE_SLOPE_LIMIT,
    .REVERTIVE_EN, .FREQ_OFFSET_APPLY);

// ===== rqd_ctrl_bench.sv
// Self-checking bench for the qualify and loop control block
`timescale 1ns/10ps
module rqd_ctrl_bench;
    import rqd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] reg_addr = '0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, lock_2k = 1'b0, lock_8k = 1'b0;
    logic [7:0] reg_wdata = '0, reg_rdata, v, d;
    logic [NUM_REF-1:0] scm_fail = '0, cfm_fail = '0, ref_qual;
    logic buildout, cap56, revert, offs, rd_seen = 1'b0, out_stb = 1'b0;
    logic [2:0] eff_bw, mode, bw, md;
    logic [1:0] slope;
    logic [7:0] q_rd[$];
    logic [11:0] q_out[$];
    logic [4:0] q_ql[$];
    logic ql_seen = 1'b0;
    logic [7:0] rst_tab[6] = '{8'hFF, 8'hFF, 8'h1A, 8'h3A, 8'h04, 8'h03};
    int mult[4] = '{2, 4, 16, 32};
    int n_errors = 0;
    int cmp_count = 0;

    always #4 clk_sys = ~clk_sys;

    rqd_ctrl #(.TICK_CYCLES(4)) dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .SINGLE_CYCLE_MONITOR_FAIL(scm_fail),
        .COARSE_FREQUENCY_MONITOR_FAIL(cfm_fail), .LOCKED_REF_2KHZ(lock_2k),
        .LOCKED_REF_8KHZ(lock_8k), .REF_QUALIFIED(ref_qual),
        .PHASE_BUILDOUT_EN(buildout), .EFF_BANDWIDTH(eff_bw),
        .BW_CAP_56HZ(cap56), .PHASE_SLOPE_LIMIT(slope), .REVERTIVE_EN(revert),
        .FREQ_OFFSET_APPLY(offs), .LOOP_MODE(mode));

    task automatic cmp(input string nm, input logic [11:0] e, logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Oldest note is compared as each result shows up
    always @(posedge clk_sys) begin
        if (rd_seen)
            cmp("reg_rdata", q_rd.pop_front(), reg_rdata);
        if (out_stb)
            cmp("controls", q_out.pop_front(),
                {buildout, eff_bw, cap56, slope, revert, offs, mode});
        if (ql_seen)
            cmp("ref_qual", 12'(q_ql.pop_front()), 12'(ref_qual));
        rd_seen <= reg_rd;
        ql_seen <= reg_rd && reg_addr == 7'h19;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = 1'b1;
        @(negedge clk_sys) reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        q_rd.push_back(e);
        if (a == 7'h19)
            q_ql.push_back(e[4:0]);
        @(negedge clk_sys) reg_rd = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic ck(input logic [11:0] e);
        q_out.push_back(e);
        out_stb = 1'b1;
        @(negedge clk_sys) out_stb = 1'b0;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #40000;
        n_errors++;
        final_report();
    end

    initial begin
        void'($urandom(32'hE020FBC1));
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        ck(12'b1_101_0_11_0_0_011);
        foreach (rst_tab[i]) rd(7'h1A + 7'(i), rst_tab[i]);
        rd(7'h30, 8'h00);
        rd(7'h19, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            v = 8'($urandom);
            {lock_8k, lock_2k} = v[7:6];
            d = {2'b00, v[5:4], 3'(c), v[0]};
            wr(7'h1D, d);
            bw = (lock_2k && c inside {4, 5}) ? 3'h3 : 3'(c);
            ck({~v[0], bw, 1'(c == 5 && lock_8k && !lock_2k), v[5:4],
                5'h03});
            rd(7'h1D, d);
        end
        for (int b = 0; b < 4; b++) begin
            // Offset enable only goes on once free-run mode is selected
            md = b[1] ? 3'h2 : 3'($urandom % 5);
            wr(7'h1F, {5'h00, md});
            wr(7'h1E, {6'b000001, 2'(b)});
            ck({~v[0], 3'h7, 1'b0, v[5:4], b[0], b[1], md});
        end
        $display("test loop controls done");
        wr(7'h1C, 8'h00);
        rd(7'h1C, 8'h00);
        rd(7'h19, 8'h1F);
        for (int i = 0; i < NUM_REF; i++) begin
            wr(i < 4 ? 7'h1A : 7'h1B, ~(8'h02 << 2 * (i % 4)));
            scm_fail = 5'($urandom);
            @(negedge clk_sys);
            rd(7'h19, 8'h1F);
            cfm_fail = 5'(1 << i);
            @(negedge clk_sys);
            rd(7'h19, 8'h1F & ~8'(1 << i));
            cfm_fail = '0;
        end
        $display("test masks done");
        wr(7'h1A, 8'hFE);
        foreach (mult[k]) begin
            wr(7'h1C, {2'b00, 2'(k), 4'h1});
            scm_fail = 5'h01;
            repeat (10) @(negedge clk_sys);
            scm_fail = '0;
            rd(7'h19, 8'h1E);
            repeat (4 * mult[k] - 8) @(negedge clk_sys);
            rd(7'h19, 8'h1E);
            repeat (12) @(negedge clk_sys);
            rd(7'h19, 8'h1F);
        end
        $display("test soak timer done");
        final_report();
    end
endmodule
